/* File: src/gpi_pkg.sv */
// Constants shared by the pin interface: address map, fields, resets.
package gpi_pkg;

    localparam int GPI_AW = 12;
    localparam int GPI_DW = 32;
    localparam int GPI_MAX_PINS = 128;
    localparam int GPI_GRP_W = 32;

    // Byte offsets of the register banks
    localparam logic [11:0] CTRL1_BASE = 12'h000;
    localparam logic [11:0] CTRL2_BASE = 12'h200;
    localparam logic [11:0] OUT_BASE = 12'h380;
    localparam logic [11:0] IN_BASE = 12'h390;
    localparam logic [11:0] STS_BASE = 12'h3a0;
    localparam logic [11:0] MSK_BASE = 12'h3b0;

    // Pin control word 1 fields
    localparam int PULL_UP_BIT = 0;
    localparam int PULL_DN_BIT = 1;
    localparam int INTDET_LSB = 4;
    localparam int INTDET_W = 2;
    localparam int DIR_BIT = 9;
    localparam int OUTSEL_BIT = 10;
    localparam int MUX_LSB = 12;
    localparam int MUX_W = 2;
    localparam int ALTOUT_BIT = 16;
    localparam int PADIN_BIT = 24;

    localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL1_WMASK = 32'h0001_3633;
    localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL2_WMASK = 32'h0000_00ff;
    localparam int DRV_W = 8;
    localparam logic [31:0] GRP_RST = 32'h0000_0000;

    localparam logic [1:0] MUX_GPIO = 2'h0;
    localparam int ALT_FUNCS = 3;

    typedef enum logic [1:0] {
        DET_LOW = 2'h0,
        DET_HIGH = 2'h1,
        DET_RISE = 2'h2,
        DET_FALL = 2'h3
    } gpi_det_e;

endpackage

/* File: src/gpi_sync.sv */
// Two-stage synchroniser for a vector of pad inputs.
`timescale 1ns/1ps
module gpi_sync
    import gpi_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage is read by the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

/* File: src/gpi_event.sv */
// Per-pin event detector: level or edge, chosen by a 2-bit select.
`timescale 1ns/1ps
module gpi_event
    import gpi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    input wire logic [INTDET_W-1:0] det_sel,
    output logic event_out
);

    logic prev_q;
    logic evt_q;
    logic evt_d;
    gpi_det_e det;

    assign det = gpi_det_e'(det_sel);

    always_comb begin
        case (det)
            DET_LOW: evt_d = ~level;
            DET_HIGH: evt_d = level;
            DET_RISE: evt_d = level & ~prev_q;
            DET_FALL: evt_d = ~level & prev_q;
            default: evt_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            evt_q <= 1'b0;
        end else begin
            prev_q <= level;
            evt_q <= evt_d;
        end
    end

    assign event_out = evt_q;

endmodule

/* File: src/gpi_top.sv */
// General purpose pin interface with APB registers, events and pad mux.
//
// Notes on behaviour
// [RULE_01] Each pin raises its own event, also wake
// [RULE_02] Detect high, low, rising or falling per field
// [RULE_03] Bit 10 picks grouped or per-pin output
// [RULE_04] Outputs grouped in 32-bit output registers
// [RULE_05] Bit 16 per-pin output, reads written value
// [RULE_06] Grouped input registers read current pad levels
// [RULE_07] Bit 24 read-only, shows current pad input
// [RULE_08] Pins numbered from zero, index sets address
// [RULE_09] Control word offsets follow pin index order
// [RULE_10] Two control words; mux field routes function
// [RULE_11] Main reset pin input path always active
// [RULE_12] Software keeps resume reset pin at default
// [RULE_13] Boot code sets keyscan pull-ups, 00003001h
// [RULE_14] Pad inputs pass two-stage synchroniser first; main_reset_input_n takes pad_in[RST_PIN] directly, bypassing it
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module gpi_top
    import gpi_pkg::*;
#(
    parameter int NPINS = 128,
    parameter int RST_PIN = 89
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GPI_AW-1:0] paddr,
    input wire logic [GPI_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [GPI_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] pad_in,
    output logic [NPINS-1:0] pad_out,
    output logic [NPINS-1:0] pad_oe,
    output logic [NPINS-1:0] pad_pull_up,
    output logic [NPINS-1:0] pad_pull_dn,
    output logic [NPINS*DRV_W-1:0] pad_drive_cfg,
    input wire logic [NPINS*ALT_FUNCS-1:0] alt_out,
    input wire logic [NPINS*ALT_FUNCS-1:0] alt_oe,
    output logic [NPINS-1:0] func_in,
    output logic [NPINS-1:0] gpio_event,
    output logic wake_event,
    output logic irq,
    output logic main_reset_input_n
);

    localparam int NGRP = (NPINS + GPI_GRP_W - 1) / GPI_GRP_W;
    localparam int GW = NGRP * GPI_GRP_W;

    initial begin
        if (NPINS < 1 || NPINS > GPI_MAX_PINS) begin
            $error("NPINS out of range");
        end
        if (RST_PIN < 0 || RST_PIN >= NPINS) begin
            $error("RST_PIN out of range");
        end
    end

    // Bus decode
    logic [9:0] word_idx;
    logic wr_en;
    logic rd_setup;
    logic [31:0] be_mask;
    logic [31:0] wdata_be;
    logic hit_any;
    logic [31:0] rd_word;
    logic [31:0] prdata_q;

    assign word_idx = paddr[11:2];
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign be_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata_be = pwdata & be_mask;

    // Per-pin state
    logic [31:0] ctrl1_q [NPINS];
    logic [31:0] ctrl2_q [NPINS];
    logic [31:0] c1_rd [NPINS];
    logic [NPINS-1:0] c1_hit;
    logic [NPINS-1:0] c2_hit;
    logic [NPINS-1:0] pad_s;
    logic [NPINS-1:0] evt;
    logic [NPINS-1:0] pad_out_q;
    logic [NPINS-1:0] pad_oe_q;

    // Grouped state
    logic [GW-1:0] out_q;
    logic [GW-1:0] sts_q;
    logic [GW-1:0] msk_q;
    logic [GW-1:0] pad_wide;
    logic [GW-1:0] sts_clr;
    logic [NGRP-1:0] out_hit;
    logic [NGRP-1:0] in_hit;
    logic [NGRP-1:0] sts_hit;
    logic [NGRP-1:0] msk_hit;
    logic irq_q;
    logic wake_q;

    localparam logic [GW-1:0] PIN_VALID = {GW{1'b1}} >> (GW - NPINS);

    gpi_sync #(
        .W(NPINS)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pad_in),
        .sync_out(pad_s)
    ); // [RULE_14]

    assign pad_wide = GW'(pad_s);

    genvar i;
    generate
        for (i = 0; i < NPINS; i++) begin : g_pin
            localparam logic [9:0] C1_IDX = CTRL1_BASE[11:2] + 10'(i); // [RULE_09]
            localparam logic [9:0] C2_IDX = CTRL2_BASE[11:2] + 10'(i);
            logic [1:0] mux;
            logic gpio_data;
            logic alt_d;
            logic alt_e;
            logic out_d;
            logic oe_d;
            logic [31:0] c1_wm;
            logic [31:0] c2_wm;

            // Index in the map is the pin number itself
            assign c1_hit[i] = (word_idx == C1_IDX); // [RULE_08]
            assign c2_hit[i] = (word_idx == C2_IDX); // [RULE_10]
            assign c1_wm = be_mask & CTRL1_WMASK;
            assign c2_wm = be_mask & CTRL2_WMASK;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl1_q[i] <= CTRL1_RST;
                    ctrl2_q[i] <= CTRL2_RST;
                end else begin
                    if (wr_en && c1_hit[i]) begin
                        ctrl1_q[i] <= (ctrl1_q[i] & ~c1_wm) | (pwdata & c1_wm);
                    end
                    if (wr_en && c2_hit[i]) begin
                        ctrl2_q[i] <= (ctrl2_q[i] & ~c2_wm) | (pwdata & c2_wm);
                    end
                end
            end

            // Bit 24 is never stored; the pad level is spliced in on read
            assign c1_rd[i] = (ctrl1_q[i] & ~(32'h1 << PADIN_BIT))
                | ({31'h0, pad_s[i]} << PADIN_BIT); // [RULE_07] [RULE_05]

            gpi_event u_evt (
                .pclk(pclk),
                .presetn(presetn),
                .level(pad_s[i]),
                .det_sel(ctrl1_q[i][INTDET_LSB +: INTDET_W]),
                .event_out(evt[i])
            ); // [RULE_02]

            // Output source select then function mux
            assign gpio_data = ctrl1_q[i][OUTSEL_BIT] ? ctrl1_q[i][ALTOUT_BIT]
                : out_q[i]; // [RULE_03]
            assign mux = ctrl1_q[i][MUX_LSB +: MUX_W];
            assign alt_d = (mux == MUX_GPIO) ? 1'b0
                : alt_out[i*ALT_FUNCS + 32'(mux) - 1];
            assign alt_e = (mux == MUX_GPIO) ? 1'b0
                : alt_oe[i*ALT_FUNCS + 32'(mux) - 1];
            assign out_d = (mux == MUX_GPIO) ? gpio_data : alt_d; // [RULE_10]
            assign oe_d = (mux == MUX_GPIO) ? ctrl1_q[i][DIR_BIT] : alt_e;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_out_q[i] <= 1'b0;
                    pad_oe_q[i] <= 1'b0;
                end else begin
                    pad_out_q[i] <= out_d;
                    pad_oe_q[i] <= oe_d;
                end
            end

            // Sticky status; a new event beats a clear in the same cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sts_q[i] <= 1'b0;
                end else begin
                    sts_q[i] <= (sts_q[i] & ~sts_clr[i]) | evt[i]; // [RULE_01]
                end
            end

            assign pad_pull_up[i] = ctrl1_q[i][PULL_UP_BIT];
            assign pad_pull_dn[i] = ctrl1_q[i][PULL_DN_BIT];
            assign pad_drive_cfg[i*DRV_W +: DRV_W] = ctrl2_q[i][DRV_W-1:0];
        end

        // Status bits above the last pin never set
        for (i = NPINS; i < GW; i++) begin : g_pad_sts
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sts_q[i] <= 1'b0;
                end else begin
                    sts_q[i] <= 1'b0;
                end
            end
        end

        for (i = 0; i < NGRP; i++) begin : g_grp
            localparam logic [9:0] O_IDX = OUT_BASE[11:2] + 10'(i);
            localparam logic [9:0] I_IDX = IN_BASE[11:2] + 10'(i);
            localparam logic [9:0] S_IDX = STS_BASE[11:2] + 10'(i);
            localparam logic [9:0] M_IDX = MSK_BASE[11:2] + 10'(i);
            logic [31:0] vmask;

            assign vmask = PIN_VALID[i*GPI_GRP_W +: GPI_GRP_W];
            assign out_hit[i] = (word_idx == O_IDX);
            assign in_hit[i] = (word_idx == I_IDX);
            assign sts_hit[i] = (word_idx == S_IDX);
            assign msk_hit[i] = (word_idx == M_IDX);
            assign sts_clr[i*GPI_GRP_W +: GPI_GRP_W] = (wr_en && sts_hit[i])
                ? wdata_be : 32'h0000_0000;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_q[i*GPI_GRP_W +: GPI_GRP_W] <= GRP_RST;
                    msk_q[i*GPI_GRP_W +: GPI_GRP_W] <= GRP_RST;
                end else begin
                    if (wr_en && out_hit[i]) begin
                        out_q[i*GPI_GRP_W +: GPI_GRP_W] <= vmask
                            & ((out_q[i*GPI_GRP_W +: GPI_GRP_W] & ~be_mask) | wdata_be); // [RULE_04]
                    end
                    if (wr_en && msk_hit[i]) begin
                        msk_q[i*GPI_GRP_W +: GPI_GRP_W] <= vmask
                            & ((msk_q[i*GPI_GRP_W +: GPI_GRP_W] & ~be_mask) | wdata_be);
                    end
                end
            end
        end
    endgenerate

    // Read mux: or of all hit words; above 96 pins, control word 2 also hits the group words
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int p = 0; p < NPINS; p++) begin
            if (c1_hit[p]) begin
                rd_word = rd_word | c1_rd[p];
            end
            if (c2_hit[p]) begin
                rd_word = rd_word | ctrl2_q[p];
            end
        end
        for (int g = 0; g < NGRP; g++) begin
            if (out_hit[g]) begin
                rd_word = rd_word | out_q[g*GPI_GRP_W +: GPI_GRP_W];
            end
            if (in_hit[g]) begin
                rd_word = rd_word | pad_wide[g*GPI_GRP_W +: GPI_GRP_W]; // [RULE_06]
            end
            if (sts_hit[g]) begin
                rd_word = rd_word | sts_q[g*GPI_GRP_W +: GPI_GRP_W];
            end
            if (msk_hit[g]) begin
                rd_word = rd_word | msk_q[g*GPI_GRP_W +: GPI_GRP_W];
            end
        end
    end

    assign hit_any = (|c1_hit) | (|c2_hit) | (|out_hit) | (|in_hit)
        | (|sts_hit) | (|msk_hit);

    // Read data captured in setup so access needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= hit_any ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & msk_q);
            // Raw event, not sticky status, so wake drops with the condition
            wake_q <= |(GW'(evt) & msk_q); // [RULE_01]
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;
    assign func_in = pad_s;
    assign gpio_event = evt; // [RULE_01]
    assign wake_event = wake_q;
    assign irq = irq_q;
    // Unclocked on purpose: reset must work with the clock stopped
    assign main_reset_input_n = pad_in[RST_PIN]; // [RULE_11]

endmodule

/* File: verif/gpi_top_sva.sv */
// Port-level assertions for the pin interface.
`timescale 1ns/1ps
module gpi_top_chk
    import gpi_pkg::*;
#(
    parameter int NPINS = 128,
    parameter int RST_PIN = 89
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GPI_AW-1:0] paddr,
    input wire logic [GPI_DW-1:0] prdata,
    input wire logic pslverr,
    input wire logic [NPINS-1:0] pad_in,
    input wire logic [NPINS-1:0] pad_out,
    input wire logic [NPINS-1:0] pad_oe,
    input wire logic [NPINS*ALT_FUNCS-1:0] alt_out,
    input wire logic [NPINS*ALT_FUNCS-1:0] alt_oe,
    input wire logic [NPINS-1:0] func_in,
    input wire logic [NPINS-1:0] gpio_event,
    input wire logic wake_event,
    input wire logic main_reset_input_n
);
    localparam logic [11:0] CTRL1_END = CTRL1_BASE + 12'(4 * NPINS);
    logic [1:0] up_q;
    logic [1:0] up_d;
    // Synchroniser history is only valid once it has refilled after reset
    assign up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_q <= 2'h0;
        else up_q <= up_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    sequence s_unmapped_rd;
        psel && penable && !pwrite && paddr >= CTRL1_END && paddr < CTRL2_BASE;
    endsequence
    property p_err; s_unmapped_rd |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped read accepted");
    property p_ok; psel && penable && paddr < CTRL1_END |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("pin word refused");
    property p_rstpin; main_reset_input_n == pad_in[RST_PIN]; endproperty
    a_rstpin: assert property (p_rstpin) else $error("reset path blocked");
    property p_sync; up_q == 2'h3 |-> func_in == $past(pad_in, 2); endproperty
    a_sync: assert property (p_sync) else $error("sync latency wrong");
    property p_in_rd; s_rd(IN_BASE) |-> prdata == 32'($past(func_in)); endproperty
    a_in_rd: assert property (p_in_rd) else $error("input group stale");
    property p_bit24; s_rd(12'h010) |-> prdata[24] == $past(func_in[4]); endproperty
    a_bit24: assert property (p_bit24) else $error("pad bit stale");
    property p_wake; wake_event |-> $past(|gpio_event); endproperty
    a_wake: assert property (p_wake) else $error("wake without event");
    property p_hold;
        !$past(psel && penable && pwrite, 2) && $past(alt_out) == $past(alt_out, 2)
            && $past(alt_oe) == $past(alt_oe, 2) |-> $stable(pad_out) && $stable(pad_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("pad changed unprompted");
endmodule

bind gpi_top gpi_top_chk #(.NPINS(NPINS), .RST_PIN(RST_PIN)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .func_in(func_in), .gpio_event(gpio_event), .wake_event(wake_event),
    .main_reset_input_n(main_reset_input_n)
);

/* File: verif/gpi_pad_model.sv */
// Pad model: resolves each pad from the block, an outside source and pull-up.
`timescale 1ns/1ps
module gpi_pad_model #(
    parameter int N = 32
) (
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe,
    input wire logic [N-1:0] pad_pull_up,
    input wire logic [N-1:0] ext_lvl,
    input wire logic [N-1:0] ext_en,
    output logic [N-1:0] pad_in
);
    // Block drive wins over the outside source; no keeper on a floating pad
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl)
        | (~pad_oe & ~ext_en & pad_pull_up);
endmodule

/* File: verif/tb_top.sv */
// Testbench for the pin interface: registers, pads, events, interrupt.
`timescale 1ns/1ps
module tb_top;
    import gpi_pkg::*;
    localparam int N = 32;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [GPI_AW-1:0] paddr = 12'h000;
    logic [GPI_DW-1:0] pwdata = 32'h0000_0000;
    logic [GPI_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [N-1:0] pad_in, pad_out, pad_oe, pad_pull_up, func_in, gpio_event;
    logic [N-1:0] ext_lvl = 32'h0000_0000;
    logic [N-1:0] ext_en = 32'hffff_ffff;
    logic [N-1:0] pad_pull_dn;
    logic [N*DRV_W-1:0] pad_drive_cfg;
    // Pin 2 function 1 and pin 10 function 2 are live
    logic [N*ALT_FUNCS-1:0] alt_out = 96'h8000_0040;
    logic [N*ALT_FUNCS-1:0] alt_oe = 96'h8000_0040;
    logic wake_event, irq, main_reset_input_n;
    logic [31:0] r;
    logic e;
    int failures = 0;
    int compares = 0;

    always #12.5 pclk = ~pclk;

    gpi_top #(.NPINS(N), .RST_PIN(25)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn), .pad_drive_cfg(pad_drive_cfg),
        .alt_out(alt_out),
        .alt_oe(alt_oe), .func_in(func_in), .gpio_event(gpio_event),
        .wake_event(wake_event), .irq(irq), .main_reset_input_n(main_reset_input_n)
    );
    gpi_pad_model #(.N(N)) u_pads (
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
        .ext_lvl(ext_lvl), .ext_en(ext_en), .pad_in(pad_in)
    );

    task end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_sim;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_regs;
        apb(1'b1, 12'h014, 32'hffff_cfff);
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h014, 32'h0);
        chk(r, 32'h0101_0633, "pin5 ctrl");
        apb(1'b1, 12'h018, 32'h0000_3001);
        ext_en[6] <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h018, 32'h0);
        chk(r, 32'h0100_3001, "keyscan ctrl");
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped err");
        chk(r, 32'h0, "unmapped data");
        apb(1'b1, 12'h214, 32'hffff_ffff);
        apb(1'b0, 12'h214, 32'h0);
        chk(r, 32'h0000_00ff, "pin5 ctrl2");
        chk({24'h0, pad_drive_cfg[5*DRV_W +: DRV_W]}, 32'h0000_00ff, "drive cfg");
        chk({30'h0, pad_pull_up[5], pad_pull_dn[5]}, 32'h3, "pin5 pulls");
        // Pin 9 stands in for the resume reset pin; never written here
        apb(1'b0, 12'h024, 32'h0);
        chk(r, CTRL1_RST, "resume pin ctrl");
        chk({31'h0, pad_oe[9]}, 32'h0, "resume pin oe");
        $display("t_regs done");
    endtask

    task t_out;
        apb(1'b1, OUT_BASE, 32'ha5a5_a5a5);
        apb(1'b1, 12'h01c, 32'h0000_0200);
        apb(1'b1, 12'h00c, 32'h0000_0200);
        apb(1'b1, 12'h008, 32'h0000_1000);
        apb(1'b1, 12'h028, 32'h0000_2000);
        repeat (2) @(posedge pclk);
        chk({pad_out[10], pad_out[7], pad_out[3], pad_out[2], pad_oe[10], pad_oe[3], pad_oe[2]},
            32'h6f, "outs");
        apb(1'b1, 12'h00c, 32'h0001_0600);
        repeat (2) @(posedge pclk);
        chk({31'h0, pad_out[3]}, 32'h1, "pin out");
        $display("t_out done");
    endtask

    task t_in;
        ext_lvl <= 32'h1234_5678;
        repeat (4) @(posedge pclk);
        apb(1'b0, IN_BASE, 32'h0);
        chk(r, 32'h1234_56fc, "input group");
        apb(1'b0, 12'h010, 32'h0);
        chk(r, 32'h0100_0000, "pin4 ctrl");
        apb(1'b1, 12'h004, 32'h0100_0000);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h0, "pin1 ctrl");
        chk({31'h0, main_reset_input_n}, 32'h1, "reset pin high");
        ext_lvl[25] <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, main_reset_input_n}, 32'h0, "reset pin low");
        $display("t_in done");
    endtask

    task t_evt;
        logic act;
        for (int m = 0; m < 4; m++) begin
            act = (m == 1) || (m == 2);
            apb(1'b1, CTRL1_BASE, 32'(m) << INTDET_LSB);
            ext_lvl[0] <= !act;
            repeat (6) @(posedge pclk);
            apb(1'b1, STS_BASE, 32'hffff_ffff);
            apb(1'b0, STS_BASE, 32'h0);
            chk({31'h0, r[0]}, 32'h0, "idle status");
            ext_lvl[0] <= act;
            repeat (6) @(posedge pclk);
            apb(1'b0, STS_BASE, 32'h0);
            chk({31'h0, r[0]}, 32'h1, "event status");
        end
        apb(1'b1, MSK_BASE, 32'h1);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "irq set");
        apb(1'b1, MSK_BASE, 32'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, CTRL1_BASE, 32'h0000_0010);
        apb(1'b1, MSK_BASE, 32'h1);
        ext_lvl[0] <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({30'h0, wake_event, gpio_event[0]}, 32'h3, "wake");
        ext_lvl[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, STS_BASE, 32'h1);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("t_evt done");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_out;
        t_in;
        t_evt;
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_sim;
    end
endmodule
